// >>> core/svwd_top.sv
// Processor supervisor: supply, power-up, push-button and watchdog reset
// Operation
// - Two complementary reset outputs assert and release together.
// - Resets assert while the selected supply comparator reports low.
// - Resets assert through power-up until supply first is in tolerance.
// - Resets stay asserted at least 250 ms after supply recovers.
// - Tolerance select low picks the 10% trip, high picks the 20% trip.
// - A debounced low push-button asserts resets, held 250 ms after.
// - The push-button is debounced and lows over 20 ms always count.
// - Period select gives about 150, 610 or 1200 ms watchdog periods.
// - No valid strobe within the period produces a reset.
// - Only a high-to-low strobe edge restarts the watchdog period.
// - The watchdog cannot be disabled and runs whenever out of reset.
// - Strobe pulses of 20 ns are caught at full clock rate.
// - A stably low push-button asserts resets within 20 ms.
`timescale 1ns/1ps
module svwd_top #(
  parameter int TICK_CYCLES = svwd_pkg::TICK_CYCLES_DEF
) (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic SUPPLY_BELOW_10,
  input wire logic SUPPLY_BELOW_20,
  input wire logic TRIP_TOLERANCE_SELECT,
  input wire logic [1:0] WATCHDOG_PERIOD_SELECT,
  input wire logic WATCHDOG_STROBE_N,
  input wire logic MANUAL_RESET_N,
  output logic RESET_OUT,
  output logic RESET_OUT_N
);
  typedef struct packed {
    logic [svwd_pkg::PIN_W-1:0] s1;
    logic [svwd_pkg::PIN_W-1:0] s2;
    logic strobe_d;
    logic up_done;
    svwd_pkg::svwd_wd_t wd_cnt;
    svwd_pkg::svwd_str_t stretch;
    logic rst;
    logic rst_n;
  } svwd_core_s;

  localparam svwd_core_s ST_RST = '{
    s1: svwd_pkg::PIN_IDLE,
    s2: svwd_pkg::PIN_IDLE,
    strobe_d: 1'b1,
    up_done: 1'b0,
    wd_cnt: '0,
    stretch: '0,
    rst: 1'b1,
    rst_n: 1'b0
  };

  localparam svwd_pkg::svwd_str_t STRETCH_LAST =
    svwd_pkg::STR_W'(svwd_pkg::STRETCH_MS);

  svwd_ctl_if ctl ();

  svwd_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .bus(ctl.divider)
  );

  svwd_debounce u_debounce (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .bus(ctl.debounce)
  );

  assign ctl.manual_pin_n = MANUAL_RESET_N;

  // Period select; the floating level is resolved by the pad
  function automatic svwd_pkg::svwd_wd_t wd_period(input logic [1:0] sel);
    if (sel == svwd_pkg::SEL_LOW) begin
      return svwd_pkg::WD_W'(svwd_pkg::WD_SHORT_MS);
    end else if (sel == svwd_pkg::SEL_FLOAT) begin
      return svwd_pkg::WD_W'(svwd_pkg::WD_MID_MS);
    end else begin
      return svwd_pkg::WD_W'(svwd_pkg::WD_LONG_MS);
    end
  endfunction

  svwd_core_s st_r;
  svwd_core_s st_nxt;
  logic below_sel;
  logic strobe_fall;
  logic wd_timeout;
  logic cause;
  svwd_pkg::svwd_wd_t period;
  logic [1:0] sel_sync;

  // Tolerance select steers which comparator trips the reset
  always_comb begin
    if (st_r.s2[svwd_pkg::PIN_TOL]) begin
      below_sel = st_r.s2[svwd_pkg::PIN_BELOW20];
    end else begin
      below_sel = st_r.s2[svwd_pkg::PIN_BELOW10];
    end
  end

  // Edge found at full clock rate, not on the slow tick
  assign strobe_fall = st_r.strobe_d &&
    !st_r.s2[svwd_pkg::PIN_STROBE_N];

  assign sel_sync = st_r.s2[svwd_pkg::PIN_SEL_HI:svwd_pkg::PIN_SEL_LO];
  assign period = wd_period(sel_sync);

  // No enable term anywhere: the timer cannot be switched off
  // At-or-beyond, so a period shortened mid-count still fires
  assign wd_timeout = ctl.tick && !st_r.rst && !strobe_fall &&
    (st_r.wd_cnt >= period - 1'b1);

  // Any cause still present holds the stretch at its start
  assign cause = below_sel || !st_r.up_done || ctl.manual_low ||
    wd_timeout;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = {WATCHDOG_PERIOD_SELECT, WATCHDOG_STROBE_N,
      TRIP_TOLERANCE_SELECT, SUPPLY_BELOW_20, SUPPLY_BELOW_10};
    st_nxt.s2 = st_r.s1;
    st_nxt.strobe_d = st_r.s2[svwd_pkg::PIN_STROBE_N];

    // Power-up ends the first time the supply is in tolerance
    if (!below_sel) begin
      st_nxt.up_done = 1'b1;
    end

    // Watchdog counts ticks only while the outputs are released
    if (st_r.rst || wd_timeout) begin
      st_nxt.wd_cnt = '0;
    end else if (strobe_fall) begin
      st_nxt.wd_cnt = '0;
    end else if (ctl.tick) begin
      st_nxt.wd_cnt = st_r.wd_cnt + 1'b1;
    end

    // Stretch: one extra tick guards against a partial first tick
    if (cause) begin
      st_nxt.rst = 1'b1;
      st_nxt.stretch = '0;
    end else if (st_r.rst && ctl.tick) begin
      if (st_r.stretch == STRETCH_LAST) begin
        st_nxt.rst = 1'b0;
      end else begin
        st_nxt.stretch = st_r.stretch + 1'b1;
      end
    end
    st_nxt.rst_n = !st_nxt.rst;
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign RESET_OUT = st_r.rst;
  assign RESET_OUT_N = st_r.rst_n;

  // Checks
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!ARST_N);

  localparam int MIN_STRETCH_CYC = svwd_pkg::STRETCH_MS * TICK_CYCLES;
  localparam int MAX_STRETCH_CYC = (svwd_pkg::STRETCH_MS + 2) * TICK_CYCLES;

  // Cycles the outputs have stayed asserted with no cause present
  int unsigned quiet_q;
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      quiet_q <= 0;
    end else if (cause || !st_r.rst) begin
      quiet_q <= 0;
    end else begin
      quiet_q <= quiet_q + 1;
    end
  end

  chk_outputs_complement: assert property (
    RESET_OUT != RESET_OUT_N
  ) else $error("reset outputs not complementary");

  chk_supply_low_reset: assert property (
    below_sel |=> RESET_OUT && !RESET_OUT_N
  ) else $error("supply low without reset");

  chk_powerup_held: assert property (
    !st_r.up_done |-> RESET_OUT
  ) else $error("reset released during power-up");

  chk_stretch_min: assert property (
    $fell(RESET_OUT) |-> $past(quiet_q) + 1 >= MIN_STRETCH_CYC
  ) else $error("reset released before stretch time");

  chk_stretch_bounded: assert property (
    quiet_q <= MAX_STRETCH_CYC
  ) else $error("reset held far beyond stretch time");

  chk_powerup_done: assert property (
    $rose(st_r.up_done) |-> !$past(below_sel)
  ) else $error("power-up ended with supply low");

  chk_tol_pick: assert property (
    st_r.s2[svwd_pkg::PIN_TOL] && st_r.s2[svwd_pkg::PIN_BELOW20] |=>
      RESET_OUT
  ) else $error("20 percent trip not selected");

  chk_tol_pick_low: assert property (
    !st_r.s2[svwd_pkg::PIN_TOL] && st_r.s2[svwd_pkg::PIN_BELOW10] |=>
      RESET_OUT
  ) else $error("10 percent trip not selected");

  chk_manual_reset: assert property (
    ctl.manual_low |=> RESET_OUT ##0 !RESET_OUT_N
  ) else $error("push-button low without reset");

  chk_manual_hold: assert property (
    $fell(ctl.manual_low) |=> RESET_OUT [*8]
  ) else $error("reset not held after push-button");

  chk_wd_period: assert property (
    st_r.wd_cnt < period |=> st_r.wd_cnt < period || $changed(period)
  ) else $error("watchdog count beyond period");

  chk_wd_fire: assert property (
    wd_timeout |=> RESET_OUT && st_r.wd_cnt == '0
  ) else $error("watchdog timeout without reset");

  chk_wd_overrun: assert property (
    ctl.tick && !st_r.rst && !strobe_fall && st_r.wd_cnt >= period |=>
      RESET_OUT
  ) else $error("watchdog overran a shortened period");

  // Period decode, one check per select level
  chk_period_short: assert property (
    sel_sync == svwd_pkg::SEL_LOW |->
      period == svwd_pkg::WD_W'(svwd_pkg::WD_SHORT_MS)
  ) else $error("short watchdog period not chosen");

  chk_period_mid: assert property (
    sel_sync == svwd_pkg::SEL_FLOAT |->
      period == svwd_pkg::WD_W'(svwd_pkg::WD_MID_MS)
  ) else $error("middle watchdog period not chosen");

  chk_period_long: assert property (
    sel_sync != svwd_pkg::SEL_LOW && sel_sync != svwd_pkg::SEL_FLOAT |->
      period == svwd_pkg::WD_W'(svwd_pkg::WD_LONG_MS)
  ) else $error("long watchdog period not chosen");

  chk_level_no_restart: assert property (
    !strobe_fall && !st_r.rst && !ctl.tick && !wd_timeout |=>
      st_r.wd_cnt == $past(st_r.wd_cnt)
  ) else $error("watchdog restarted without strobe edge");

  chk_strobe_restart: assert property (
    strobe_fall && !st_r.rst |=> st_r.wd_cnt == '0
  ) else $error("strobe edge did not restart watchdog");

  chk_wd_runs: assert property (
    !st_r.rst && ctl.tick && !strobe_fall && !wd_timeout |=>
      st_r.wd_cnt == $past(st_r.wd_cnt) + 1'b1
  ) else $error("watchdog stalled while out of reset");

  chk_wd_cleared: assert property (
    st_r.rst |=> st_r.wd_cnt == '0
  ) else $error("watchdog counted during reset");

  chk_cause_merge: assert property (
    cause |=> st_r.stretch == '0 ##0 RESET_OUT
  ) else $error("stretch not restarted by cause");

  cov_supply_release: cover property (
    st_r.up_done ##1 $fell(RESET_OUT)
  );

  cov_manual_reset: cover property (
    $rose(ctl.manual_low) ##[1:3] RESET_OUT
  );

  cov_wd_timeout: cover property (
    wd_timeout ##1 RESET_OUT
  );

  cov_strobe_kick: cover property (
    strobe_fall && !st_r.rst && st_r.wd_cnt != '0
  );

  cov_tol_high_trip: cover property (
    st_r.s2[svwd_pkg::PIN_TOL] && below_sel ##3 RESET_OUT
  );
endmodule

// >>> shared/svwd_pkg.sv
// Constants and types shared by the supervisor watchdog reset block
package svwd_pkg;
  // Clock and slow timing base
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // Times in milliseconds, counted in ticks
  localparam int STRETCH_MS = 250;
  localparam int DEBOUNCE_MS = 10;
  localparam int MANUAL_MAX_MS = 20;
  localparam int MANUAL_MIN_LOW_MS = 20;
  localparam int WD_SHORT_MS = 150;
  localparam int WD_MID_MS = 610;
  localparam int WD_LONG_MS = 1200;

  // Counter widths
  localparam int WD_W = 11;
  localparam int STR_W = 9;
  localparam int DB_W = 5;

  typedef logic [WD_W-1:0] svwd_wd_t;
  typedef logic [STR_W-1:0] svwd_str_t;
  typedef logic [DB_W-1:0] svwd_db_t;

  // Encoded three-level period select
  localparam logic [1:0] SEL_LOW = 2'h0;
  localparam logic [1:0] SEL_FLOAT = 2'h1;

  // Bit positions of the synchronised pin vector
  localparam int PIN_BELOW10 = 0;
  localparam int PIN_BELOW20 = 1;
  localparam int PIN_TOL = 2;
  localparam int PIN_STROBE_N = 3;
  localparam int PIN_SEL_LO = 4;
  localparam int PIN_SEL_HI = 5;
  localparam int PIN_W = 6;
  // Idle reads supply low, so power-up waits for real samples
  localparam logic [PIN_W-1:0] PIN_IDLE = 6'h0B;
endpackage

// >>> shared/svwd_ctl_if.sv
// Carrier between the tick divider, the push-button debouncer and the core
`timescale 1ns/1ps
interface svwd_ctl_if;
  logic tick;
  logic manual_pin_n;
  logic manual_low;
  modport divider (output tick);
  modport debounce (input tick, input manual_pin_n, output manual_low);
  modport core (input tick, input manual_low, output manual_pin_n);
endinterface

// >>> core/svwd_tick.sv
// One-millisecond tick divider
`timescale 1ns/1ps
module svwd_tick #(
  parameter int TICK_CYCLES = svwd_pkg::TICK_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic arst_n,
  svwd_ctl_if.divider bus
);
  localparam int CW = $clog2(TICK_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } svwd_tick_s;

  svwd_tick_s st_r;
  svwd_tick_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (st_r.cnt == LAST) begin
      st_nxt.cnt = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus.tick = st_r.tick;
endmodule

// >>> core/svwd_debounce.sv
// Push-button synchroniser and debouncer
`timescale 1ns/1ps
module svwd_debounce (
  input wire logic clk,
  input wire logic arst_n,
  svwd_ctl_if.debounce bus
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic stable_low;
    svwd_pkg::svwd_db_t cnt;
  } svwd_db_s;

  localparam svwd_pkg::svwd_db_t DB_LAST =
    svwd_pkg::DB_W'(svwd_pkg::DEBOUNCE_MS - 1);

  svwd_db_s st_r;
  svwd_db_s st_nxt;

  // Level must hold for a full debounce span before it is believed
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = bus.manual_pin_n;
    st_nxt.s2 = st_r.s1;
    if (!st_r.s2 == st_r.stable_low) begin
      st_nxt.cnt = '0;
    end else if (bus.tick) begin
      if (st_r.cnt == DB_LAST) begin
        st_nxt.stable_low = !st_r.stable_low;
        st_nxt.cnt = '0;
      end else begin
        st_nxt.cnt = st_r.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '{s1: 1'b1, s2: 1'b1, stable_low: 1'b0, cnt: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus.manual_low = st_r.stable_low;

  // Ticks spent with the pin low but not yet recognised
  // Counted in ticks so the bound follows the divider setting
  int unsigned wait_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_q <= 0;
    end else if (!st_r.s2 && !st_r.stable_low) begin
      if (bus.tick) begin
        wait_q <= wait_q + 1;
      end
    end else begin
      wait_q <= 0;
    end
  end

  chk_manual_latency: assert property (
    @(posedge clk) disable iff (!arst_n)
    wait_q <= 32'(svwd_pkg::MANUAL_MAX_MS)
  ) else $error("manual reset not recognised in time");
endmodule

// >>> testbench/svwd_proc_model.sv
// Monitored processor model: strobes the watchdog while running
`timescale 1ns/1ps
module svwd_proc_model (
  input wire logic clk,
  input wire logic reset_in,
  input wire logic run,
  input wire logic idle_lvl,
  input wire logic [31:0] gap,
  output logic strobe_n
);
  int cnt;
  initial begin
    strobe_n = 1'b1;
    cnt = 0;
  end
  // Two-cycle low pulse once per gap; held high while in reset
  always @(negedge clk) begin
    if (reset_in) begin
      strobe_n <= 1'b1;
      cnt <= 0;
    end else if (!run) begin
      strobe_n <= idle_lvl;
      cnt <= 0;
    end else begin
      strobe_n <= !(cnt < 2);
      cnt <= (cnt + 1 >= gap) ? 0 : cnt + 1;
    end
  end
endmodule

// >>> testbench/supervisor_watchdog_reset_tb.sv
// Self-checking bench for the supervisor reset block
`timescale 1ns/1ps
module supervisor_watchdog_reset_tb;
  // Short tick keeps the 1200 ms period affordable
  localparam int TK = 4;
  logic ref_clk, arst_n, below_10, below_20, trip_tolerance_select, mrst_n;
  logic run, idle_lvl, strobe_n, rst_o, rst_o_n;
  logic [1:0] sel;
  int gap, mismatches, total_checks, n;
  int per[3] = '{150, 610, 1200};

  svwd_top #(.TICK_CYCLES(TK)) u_svwd_top (
    .REF_CLK(ref_clk), .ARST_N(arst_n),
    .SUPPLY_BELOW_10(below_10), .SUPPLY_BELOW_20(below_20),
    .TRIP_TOLERANCE_SELECT(trip_tolerance_select), .WATCHDOG_PERIOD_SELECT(sel),
    .WATCHDOG_STROBE_N(strobe_n), .MANUAL_RESET_N(mrst_n),
    .RESET_OUT(rst_o), .RESET_OUT_N(rst_o_n)
  );
  svwd_proc_model u_svwd_proc_model (
    .clk(ref_clk), .reset_in(rst_o), .run(run), .idle_lvl(idle_lvl),
    .gap(gap), .strobe_n(strobe_n)
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    if (mismatches == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic cyc(int k);
    repeat (k) @(negedge ref_clk);
  endtask

  // Bounded wait for the reset output to reach a level
  task automatic wait_lvl(logic lvl, int hi);
    n = 0;
    while (rst_o !== lvl && n <= hi * TK) begin
      cyc(1);
      n++;
    end
  endtask

  task automatic release_in(string what, int lo, int hi);
    wait_lvl(1'b0, hi);
    check(what, (n >= lo * TK && n <= hi * TK), 32'h1);
  endtask

  always @(negedge ref_clk) begin
    if (arst_n) check("complement", rst_o ^ rst_o_n, 32'h1);
  end

  task automatic t_powerup();
    cyc(20 * TK);
    check("held in power-up", rst_o, 32'h1);
    below_10 = 1'b0;
    release_in("power-up stretch", 250, 253);
  endtask

  task automatic t_tolerance();
    for (int t = 0; t < 2; t++) begin
      trip_tolerance_select = t[0];
      cyc(4);
      below_20 = ~t[0];
      below_10 = t[0];
      cyc(10);
      check("unselected trip", rst_o, 32'h0);
      below_20 = t[0];
      below_10 = ~t[0];
      cyc(3);
      check("selected trip", rst_o, 32'h1);
      below_10 = 1'b0;
      below_20 = 1'b0;
      release_in("supply stretch", 250, 253);
    end
  endtask

  task automatic t_manual();
    mrst_n = 1'b0;
    cyc(5 * TK);
    mrst_n = 1'b1;
    cyc(15 * TK);
    check("short press", rst_o, 32'h0);
    mrst_n = 1'b0;
    wait_lvl(1'b1, 20);
    check("press latency", n <= 20 * TK, 32'h1);
    cyc(25 * TK - n);
    mrst_n = 1'b1;
    release_in("press stretch", 250, 264);
  endtask

  task automatic t_watchdog();
    run = 1'b0;
    cyc(200 * TK);
    sel = 2'h0;
    wait_lvl(1'b1, 2);
    check("shortened period", n <= 2 * TK, 32'h1);
    for (int s = 0; s < 3; s++) begin
      sel = s[1:0];
      release_in("timeout stretch", 250, 253);
      wait_lvl(1'b1, per[s] + 2);
      check("period", n >= (per[s] - 2) * TK && n <= (per[s] + 1) * TK,
            32'h1);
    end
  endtask

  task automatic t_strobe();
    sel = 2'h0;
    run = 1'b1;
    release_in("stretch", 250, 253);
    wait_lvl(1'b1, 400);
    check("fed watchdog", n > 400 * TK, 32'h1);
    run = 1'b0;
    idle_lvl = 1'b0;
    wait_lvl(1'b1, 160);
    check("steady low", n <= 155 * TK, 32'h1);
    idle_lvl = 1'b1;
  endtask

  task automatic t_overlap();
    // Press lands while the watchdog reset is still stretching
    cyc(20 * TK);
    mrst_n = 1'b0;
    cyc(100 * TK);
    check("merged", rst_o, 32'h1);
    mrst_n = 1'b1;
    release_in("merged stretch", 250, 264);
  endtask

  initial begin
    mismatches = 0;
    total_checks = 0;
    arst_n = 1'b0;
    below_10 = 1'b1;
    below_20 = 1'b0;
    trip_tolerance_select = 1'b0;
    mrst_n = 1'b1;
    sel = 2'h2;
    run = 1'b1;
    idle_lvl = 1'b1;
    gap = 100 * TK;
    cyc(20);
    arst_n = 1'b1;
    t_powerup();
    t_tolerance();
    t_manual();
    t_watchdog();
    t_strobe();
    t_overlap();
    wrap_up();
  end

  // Whole run is near 21000 cycles
  initial begin
    cyc(60000);
    mismatches++;
    wrap_up();
  end
endmodule
